//--- ncoacc_pkg.sv
// Purpose: Shared constants for the phase accumulator oscillator block.
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register.
// Notes:   Registers carry up to 8 significant bits in the low byte.
package ncoacc_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          ACC_W         = 20;
	localparam int          SRC_N         = 16;
	localparam logic [7:0]  OFF_CONTROL   = 8'h00;
	localparam logic [7:0]  OFF_SRC_PULSE = 8'h04;
	localparam logic [7:0]  OFF_ACC_LOW   = 8'h08;
	localparam logic [7:0]  OFF_ACC_HIGH  = 8'h0C;
	localparam logic [7:0]  OFF_ACC_UPPER = 8'h10;
	localparam logic [7:0]  OFF_STEP_LOW  = 8'h14;
	localparam logic [7:0]  OFF_STEP_HIGH = 8'h18;
	localparam logic [7:0]  OFF_STEP_UPPER = 8'h1C;
	localparam logic [7:0]  OFF_IRQ_STATUS = 8'h20;
	localparam logic [7:0]  OFF_IRQ_MASK  = 8'h24;
	localparam int          CTL_EN_BIT    = 7;
	localparam int          CTL_OUT_BIT   = 5;
	localparam int          CTL_POL_BIT   = 4;
	localparam int          CTL_PFM_BIT   = 0;
	localparam int          PWS_LSB       = 5;
	localparam int          CKS_LSB       = 0;
	localparam logic [7:0]  CTL_WR_MASK   = 8'h91;
	localparam logic [7:0]  SRC_WR_MASK   = 8'hEF;
	localparam logic [7:0]  UPPER_MASK    = 8'h0F;
	localparam logic [19:0] ACC_RST       = 20'h00000;
	localparam logic [19:0] STEP_RST      = 20'h00001;
	localparam logic [7:0]  CTL_RST       = 8'h00;
	localparam logic [7:0]  SRC_RST       = 8'h00;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : ncoacc_pkg

//--- ncoacc_top.sv
// Purpose: Phase accumulator oscillator with AXI4-Lite register access.
// Assumes: Source clocks are asynchronous pins, sampled on clock_i.
// Notes:   Source edges are seen as enables; sources must be well below half of clock_i.
`timescale 1ns/100ps
`default_nettype none
module ncoacc_top (
	input  wire logic                   clock_i,          // 100 MHz system clock
	input  wire logic                   reset_n_i,        // Async reset, active low
	input  wire logic [15:0]            source_clock_i,   // Candidate source clocks
	input  wire logic [7:0]             s_axi_awaddr_i,   // Write address
	input  wire logic                   s_axi_awvalid_i,  // Write address valid
	output logic                        s_axi_awready_o,  // Write address ready
	input  wire logic [31:0]            s_axi_wdata_i,    // Write data
	input  wire logic [3:0]             s_axi_wstrb_i,    // Write strobes
	input  wire logic                   s_axi_wvalid_i,   // Write data valid
	output logic                        s_axi_wready_o,   // Write data ready
	output logic [1:0]                  s_axi_bresp_o,    // Write response
	output logic                        s_axi_bvalid_o,   // Write response valid
	input  wire logic                   s_axi_bready_i,   // Write response ready
	input  wire logic [7:0]             s_axi_araddr_i,   // Read address
	input  wire logic                   s_axi_arvalid_i,  // Read address valid
	output logic                        s_axi_arready_o,  // Read address ready
	output logic [31:0]                 s_axi_rdata_o,    // Read data
	output logic [1:0]                  s_axi_rresp_o,    // Read response
	output logic                        s_axi_rvalid_o,   // Read data valid
	input  wire logic                   s_axi_rready_i,   // Read data ready
	output logic                        output_state_o,   // Oscillator output after polarity
	output logic                        irq_o             // Level interrupt, active high
);
	// Register address decode shared by the read and write paths
	function automatic logic [3:0] reg_index(input logic [7:0] addr);
		logic [3:0] idx;
		idx = 4'hF;
		if (addr[1:0] == 2'h0 && addr <= ncoacc_pkg::OFF_IRQ_MASK) begin
			idx = addr[5:2];
		end
		return idx;
	endfunction : reg_index

	logic [7:0]  awaddr_q, awaddr_d;
	logic [7:0]  wbyte_q, wbyte_d;
	logic        wlane_q, wlane_d;
	logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic        awready_q, awready_d, wready_q, wready_d;
	logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [3:0]  rd_idx_q, rd_idx_d;
	logic        wr_fire;
	logic [3:0]  wr_idx;

	logic [15:0] sync1_q, sync2_q, sync3_q;
	logic [19:0] acc_q, acc_d, step_q, step_d, shadow_q, shadow_d;
	logic [7:0]  ctl_q, ctl_d, src_q, src_d;
	logic        pend_q, pend_d, raw_q, raw_d, out_q, out_d;
	logic [7:0]  cnt_q, cnt_d;
	logic        flag_q, flag_d, mask_q, mask_d, irq_q, irq_d;
	logic        en, pfm, rise, fall, carry;
	logic [20:0] sum;
	logic [3:0]  sel;

	assign wr_fire       = aw_held_q & w_held_q & ~bvalid_q;
	assign wr_idx        = reg_index(awaddr_q);

	always_comb begin
		awaddr_d  = awaddr_q;
		wbyte_d   = wbyte_q;
		wlane_d   = wlane_q;
		aw_held_d = aw_held_q & ~wr_fire;
		w_held_d  = w_held_q & ~wr_fire;
		if (s_axi_awvalid_i && awready_q) begin
			aw_held_d = 1'b1;
			awaddr_d  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready_q) begin
			w_held_d = 1'b1;
			wbyte_d  = s_axi_wdata_i[7:0];
			wlane_d  = s_axi_wstrb_i[0];
		end
		awready_d = ~aw_held_d;
		wready_d  = ~w_held_d;
		bvalid_d  = bvalid_q & ~s_axi_bready_i;
		bresp_d   = bresp_q;
		if (wr_fire) begin
			bvalid_d = 1'b1;
			bresp_d  = (wr_idx == 4'hF) ? ncoacc_pkg::RESP_SLVERR : ncoacc_pkg::RESP_OKAY;
		end
		rvalid_d = rvalid_q & ~s_axi_rready_i;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		rd_idx_d = rd_idx_q;
		if (s_axi_arvalid_i && arready_q) begin
			rvalid_d = 1'b1;
			rd_idx_d = reg_index(s_axi_araddr_i);
			rresp_d  = ncoacc_pkg::RESP_OKAY;
			rdata_d  = 32'h00000000;
			unique case (s_axi_araddr_i)
				ncoacc_pkg::OFF_CONTROL: begin
					rdata_d[7:0] = {ctl_q[7:6], out_q, ctl_q[4:0]};
				end
				ncoacc_pkg::OFF_SRC_PULSE:  rdata_d[7:0] = src_q;
				ncoacc_pkg::OFF_ACC_LOW:    rdata_d[7:0] = acc_q[7:0];
				ncoacc_pkg::OFF_ACC_HIGH:   rdata_d[7:0] = acc_q[15:8];
				ncoacc_pkg::OFF_ACC_UPPER:  rdata_d[7:0] = {4'h0, acc_q[19:16]};
				ncoacc_pkg::OFF_STEP_LOW:   rdata_d[7:0] = step_q[7:0];
				ncoacc_pkg::OFF_STEP_HIGH:  rdata_d[7:0] = step_q[15:8];
				ncoacc_pkg::OFF_STEP_UPPER: rdata_d[7:0] = {4'h0, step_q[19:16]};
				ncoacc_pkg::OFF_IRQ_STATUS: rdata_d[0] = flag_q;
				ncoacc_pkg::OFF_IRQ_MASK:   rdata_d[0] = mask_q;
				default:                    rresp_d = ncoacc_pkg::RESP_SLVERR;
			endcase
		end
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			awaddr_q  <= 8'h00;
			wbyte_q   <= 8'h00;
			wlane_q   <= 1'b0;
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= 2'h0;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rresp_q   <= 2'h0;
			rdata_q   <= 32'h00000000;
			rd_idx_q  <= 4'h0;
		end else begin
			awaddr_q  <= awaddr_d;
			wbyte_q   <= wbyte_d;
			wlane_q   <= wlane_d;
			aw_held_q <= aw_held_d;
			w_held_q  <= w_held_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			rd_idx_q  <= rd_idx_d;
		end
	end

	// Two-stage synchronisers for every source pin
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_q <= 16'h0000;
			sync2_q <= 16'h0000;
			sync3_q <= 16'h0000;
		end else begin
			sync1_q <= source_clock_i;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign sel  = src_q[ncoacc_pkg::CKS_LSB +: 4];
	assign rise = sync2_q[sel] & ~sync3_q[sel];
	assign fall = ~sync2_q[sel] & sync3_q[sel];
	assign en   = ctl_q[ncoacc_pkg::CTL_EN_BIT];
	assign pfm  = ctl_q[ncoacc_pkg::CTL_PFM_BIT];
	assign sum  = {1'b0, acc_q} + {1'b0, shadow_q};
	assign carry = en & rise & sum[20];

	always_comb begin
		acc_d    = acc_q;
		step_d   = step_q;
		ctl_d    = ctl_q;
		src_d    = src_q;
		pend_d   = pend_q;
		shadow_d = shadow_q;
		raw_d    = raw_q;
		cnt_d    = cnt_q;
		mask_d   = mask_q;
		if (en && rise) begin
			acc_d = sum[19:0];
		end
		if (en && pfm && rise && raw_q) begin
			if (cnt_q == 8'h00) begin
				raw_d = 1'b0;
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
		end
		if (carry) begin
			if (pfm) begin
				raw_d = 1'b1;
				cnt_d = 8'(8'h01 << src_q[ncoacc_pkg::PWS_LSB +: 3]) - 8'h01;
			end else begin
				raw_d = ~raw_q;
			end
		end
		if (en && fall && pend_q) begin
			shadow_d = step_q;
			pend_d   = 1'b0;
		end
		if (!en) begin
			shadow_d = step_q;
			pend_d   = 1'b0;
		end
		flag_d = (flag_q | carry);
		if (wr_fire && wlane_q) begin
			unique case (wr_idx)
				4'h0: ctl_d = wbyte_q & ncoacc_pkg::CTL_WR_MASK;
				4'h1: src_d = wbyte_q & ncoacc_pkg::SRC_WR_MASK;
				4'h2: acc_d[7:0]   = wbyte_q;
				4'h3: acc_d[15:8]  = wbyte_q;
				4'h4: acc_d[19:16] = wbyte_q[3:0];
				4'h5: begin
					step_d[7:0] = wbyte_q;
					pend_d      = en;
				end
				4'h6: step_d[15:8]  = wbyte_q;
				4'h7: step_d[19:16] = wbyte_q[3:0];
				4'h8: flag_d = (flag_q & ~wbyte_q[0]) | carry;
				4'h9: mask_d = wbyte_q[0];
				default: begin
				end
			endcase
		end
		out_d = raw_d ^ ctl_d[ncoacc_pkg::CTL_POL_BIT];
		irq_d = flag_d & mask_d & ctl_d[ncoacc_pkg::CTL_EN_BIT];
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			acc_q    <= ncoacc_pkg::ACC_RST;
			step_q   <= ncoacc_pkg::STEP_RST;
			shadow_q <= ncoacc_pkg::STEP_RST;
			ctl_q    <= ncoacc_pkg::CTL_RST;
			src_q    <= ncoacc_pkg::SRC_RST;
			pend_q   <= 1'b0;
			raw_q    <= 1'b0;
			out_q    <= 1'b0;
			cnt_q    <= 8'h00;
			flag_q   <= 1'b0;
			mask_q   <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			acc_q    <= acc_d;
			step_q   <= step_d;
			shadow_q <= shadow_d;
			ctl_q    <= ctl_d;
			src_q    <= src_d;
			pend_q   <= pend_d;
			raw_q    <= raw_d;
			out_q    <= out_d;
			cnt_q    <= cnt_d;
			flag_q   <= flag_d;
			mask_q   <= mask_d;
			irq_q    <= irq_d;
		end
	end

	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o  = wready_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rresp_o   = rresp_q;
	assign s_axi_rdata_o   = rdata_q;
	assign output_state_o  = out_q;
	assign irq_o           = irq_q;

	chk_upper_reads_zero: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		rvalid_q && (rd_idx_q == 4'h4 || rd_idx_q == 4'h7) |-> rdata_q[7:4] == 4'h0)
		else $error("upper byte bits 7:4 not zero");
	chk_accum_adds: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		en && rise && !(wr_fire && wr_idx >= 4'h2 && wr_idx <= 4'h4)
		|=> acc_q == $past(sum[19:0]))
		else $error("accumulator did not add the shadow step");
	chk_flag_sticky: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		carry |=> flag_q ##1 (flag_q || $past(wr_fire)))
		else $error("overflow flag not set or lost");
	chk_shadow_falls: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		en && fall && pend_q |=> shadow_q == $past(step_q) && !pend_q)
		else $error("shadow not loaded on falling edge");
	chk_shadow_holds: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		en && !(fall && pend_q) |=> $stable(shadow_q))
		else $error("shadow changed without transfer");
	chk_disabled_copy: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		!en |=> shadow_q == $past(step_q))
		else $error("disabled shadow not copied");
	chk_fixed_toggle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		carry && !pfm |=> raw_q != $past(raw_q))
		else $error("fixed duty output did not toggle");
	chk_pulse_start: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		carry && pfm |=> raw_q && cnt_q == $past(8'(8'h01 << src_q[7:5]) - 8'h01))
		else $error("pulse did not start with right count");
	chk_pulse_end: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		en && pfm && rise && !carry && raw_q && cnt_q == 8'h00 |=> !raw_q)
		else $error("pulse did not end");
	chk_irq_level: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		##1 irq_o == $past(flag_d & mask_d & ctl_d[7]))
		else $error("interrupt level wrong");
endmodule : ncoacc_top
`default_nettype wire

//--- test_ncoacc_top.sv
// Purpose: Self-checking bench for the phase accumulator oscillator.
// Assumes: Handshakes are judged on the falling edge and driven after the rising one.
// Notes:   Source pulses stay 4 clocks high and 5 low, above the 3-cycle minimum.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
	$display("Error %s expected %h seen %h", nm, exp, got); end end
module test_ncoacc_top;
	logic             clock_i        = 1'b0;
	logic             reset_n_i      = 1'b0;
	logic [15:0]      source_clock_i = 16'h0000;
	logic [7:0]       awaddr         = 8'h00;
	logic             awvalid        = 1'b0;
	logic [31:0]      wdata          = 32'h00000000;
	logic [3:0]       wstrb          = 4'h0;
	logic             wvalid         = 1'b0;
	logic             bready         = 1'b0;
	logic [7:0]       araddr         = 8'h00;
	logic             arvalid        = 1'b0;
	logic             rready         = 1'b0;
	wire logic        awready, wready, bvalid, arready, rvalid, out_state, irq;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int               bad_count      = 0;
	int               checks_done    = 0;
	logic [1:0]       exp_bresp      = ncoacc_pkg::RESP_OKAY;

	ncoacc_top i_dut (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .source_clock_i(source_clock_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .output_state_o(out_state),
		.irq_o(irq)
	);

	always #5 clock_i = ~clock_i;

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
		logic aw_hit;
		logic w_hit;
		@(posedge clock_i);
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		// Each channel drops at the edge that takes it, so neither is taken twice
		do begin
			@(negedge clock_i);
			aw_hit = awvalid & awready;
			w_hit  = wvalid & wready;
			@(posedge clock_i);
			if (aw_hit) begin
				awvalid <= 1'b0;
			end
			if (w_hit) begin
				wvalid <= 1'b0;
			end
		end while ((awvalid & ~aw_hit) | (wvalid & ~w_hit));
		@(negedge clock_i);
		while (bvalid !== 1'b1) @(negedge clock_i);
		`CHECK("bresp", exp_bresp, bresp)
		@(posedge clock_i);
		bready <= 1'b0;
		@(negedge clock_i);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		@(negedge clock_i);
		while (arready !== 1'b1) @(negedge clock_i);
		@(posedge clock_i);
		arvalid <= 1'b0;
		@(negedge clock_i);
		while (rvalid !== 1'b1) @(negedge clock_i);
		d = rdata;
		r = rresp;
		@(posedge clock_i);
		rready <= 1'b0;
	endtask : axi_read

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		`CHECK("rdata", {24'h000000, e}, d)
		`CHECK("rresp", ncoacc_pkg::RESP_OKAY, r)
	endtask : chk_reg

	task automatic src_pulse(input int idx, input int cnt);
		repeat (cnt) begin
			@(posedge clock_i);
			source_clock_i[idx] <= 1'b1;
			repeat (4) @(posedge clock_i);
			source_clock_i[idx] <= 1'b0;
			repeat (4) @(posedge clock_i);
		end
		@(negedge clock_i);
	endtask : src_pulse

	task automatic set_step(input logic [19:0] s);
		axi_write(ncoacc_pkg::OFF_STEP_UPPER, {4'h0, s[19:16]});
		axi_write(ncoacc_pkg::OFF_STEP_HIGH, s[15:8]);
		axi_write(ncoacc_pkg::OFF_STEP_LOW, s[7:0]);
	endtask : set_step

	task automatic prep(input logic [19:0] s);
		axi_write(ncoacc_pkg::OFF_CONTROL, 8'h00);
		axi_write(ncoacc_pkg::OFF_ACC_LOW, 8'h00);
		axi_write(ncoacc_pkg::OFF_ACC_HIGH, 8'h00);
		axi_write(ncoacc_pkg::OFF_ACC_UPPER, 8'h00);
		set_step(s);
	endtask : prep

	task automatic t_reset;
		logic [7:0]  zr [5] = '{8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C};
		logic [31:0] d;
		logic [1:0]  r;
		chk_reg(ncoacc_pkg::OFF_STEP_LOW, 8'h01);
		for (int i = 0; i < 5; i++) chk_reg(zr[i], 8'h00);
		axi_read(8'h40, d, r);
		`CHECK("unmapped rresp", ncoacc_pkg::RESP_SLVERR, r)
		`CHECK("irq at reset", 1'b0, irq)
		// Unmapped write must answer with an error and change nothing
		exp_bresp = ncoacc_pkg::RESP_SLVERR;
		axi_write(8'h40, 8'h5A);
		exp_bresp = ncoacc_pkg::RESP_OKAY;
		axi_write(ncoacc_pkg::OFF_CONTROL, 8'h80);
		src_pulse(0, 1);
		axi_write(ncoacc_pkg::OFF_CONTROL, 8'h00);
		chk_reg(ncoacc_pkg::OFF_ACC_LOW, 8'h01);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_upper;
		axi_write(ncoacc_pkg::OFF_ACC_UPPER, 8'hFF);
		chk_reg(ncoacc_pkg::OFF_ACC_UPPER, 8'h0F);
		axi_write(ncoacc_pkg::OFF_STEP_UPPER, 8'hFF);
		chk_reg(ncoacc_pkg::OFF_STEP_UPPER, 8'h0F);
		$display("t_upper done");
	endtask : t_upper

	task automatic t_accum;
		prep(20'h12345);
		axi_write(ncoacc_pkg::OFF_SRC_PULSE, 8'h03);
		axi_write(ncoacc_pkg::OFF_CONTROL, 8'h80);
		// Unselected source must not advance the sum
		src_pulse(0, 1);
		src_pulse(3, 3);
		// New step lands on the falling edge after the next rise, which still adds the old one
		set_step(20'h00010);
		src_pulse(3, 3);
		axi_write(ncoacc_pkg::OFF_CONTROL, 8'h00);
		chk_reg(ncoacc_pkg::OFF_ACC_LOW, 8'h34);
		chk_reg(ncoacc_pkg::OFF_ACC_HIGH, 8'h8D);
		chk_reg(ncoacc_pkg::OFF_ACC_UPPER, 8'h04);
		$display("t_accum done");
	endtask : t_accum

	task automatic t_irq;
		prep(20'h80000);
		axi_write(ncoacc_pkg::OFF_SRC_PULSE, 8'h00);
		axi_write(ncoacc_pkg::OFF_IRQ_MASK, 8'h01);
		axi_write(ncoacc_pkg::OFF_CONTROL, 8'h80);
		src_pulse(0, 1);
		`CHECK("output", 1'b0, out_state)
		`CHECK("irq", 1'b0, irq)
		src_pulse(0, 1);
		`CHECK("output", 1'b1, out_state)
		`CHECK("irq", 1'b1, irq)
		chk_reg(ncoacc_pkg::OFF_IRQ_STATUS, 8'h01);
		axi_write(ncoacc_pkg::OFF_IRQ_MASK, 8'h00);
		@(negedge clock_i);
		`CHECK("irq masked", 1'b0, irq)
		axi_write(ncoacc_pkg::OFF_IRQ_MASK, 8'h01);
		@(negedge clock_i);
		`CHECK("irq unmasked", 1'b1, irq)
		axi_write(ncoacc_pkg::OFF_IRQ_STATUS, 8'h01);
		@(negedge clock_i);
		`CHECK("irq cleared", 1'b0, irq)
		chk_reg(ncoacc_pkg::OFF_IRQ_STATUS, 8'h00);
		src_pulse(0, 2);
		`CHECK("output", 1'b0, out_state)
		axi_write(ncoacc_pkg::OFF_CONTROL, 8'h90);
		@(negedge clock_i);
		`CHECK("inverted output", 1'b1, out_state)
		chk_reg(ncoacc_pkg::OFF_CONTROL, 8'hB0);
		$display("t_irq done");
	endtask : t_irq

	task automatic t_pulse;
		prep(20'h40000);
		// Width code 001 selects two source periods
		axi_write(ncoacc_pkg::OFF_SRC_PULSE, 8'h20);
		axi_write(ncoacc_pkg::OFF_CONTROL, 8'h81);
		src_pulse(0, 3);
		`CHECK("pulse", 1'b0, out_state)
		src_pulse(0, 1);
		`CHECK("pulse", 1'b1, out_state)
		src_pulse(0, 1);
		`CHECK("pulse", 1'b1, out_state)
		src_pulse(0, 1);
		`CHECK("pulse", 1'b0, out_state)
		$display("t_pulse done");
	endtask : t_pulse

	initial begin
		repeat (4) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		t_reset;
		t_upper;
		t_accum;
		t_irq;
		t_pulse;
		test_done;
	end

	// Tests need several hundred cycles; this leaves a wide margin
	initial begin
		#300000;
		bad_count++;
		test_done;
	end
endmodule : test_ncoacc_top
`default_nettype wire
